// ---- logic/hvac_seq_defs.svh ----
`ifndef HVAC_SEQ_DEFS_SVH
`define HVAC_SEQ_DEFS_SVH

// timing: seconds as printed, cycles derived from the 250 MHz clock
`define CLK_HZ            64'd250000000
`define CALL_DELAY_S      64'd5
`define STAGGER_DELAY_S   64'd5
`define PURGE_DEFAULT_S   8'h5A
`define CALL_DELAY_CYC    (`CALL_DELAY_S * `CLK_HZ)
`define STAGGER_CYC       (`STAGGER_DELAY_S * `CLK_HZ)
`define CYC_PER_SEC       (`CLK_HZ)

// liquid-line thresholds, degrees F
`define LL_STOP_F         8'h50
`define LL_TARGET_F       8'h5A
`define LL_MAX_F          8'h73

// speed defaults, percent of maximum
`define AUX_SPEED_RST     7'h64
`define DEHUM_SPEED_RST   7'h50
`define STAGE_SPEED_RST   7'h64
`define FAN_MAX_RST       7'h64

// call vector bit positions
`define CALL_FAN          0
`define CALL_COOL1        1
`define CALL_COOL2        2
`define CALL_AUX          3
`define CALL_DEHUM        4
`define CALL_VALVE        5
`define CALL_N            6

`endif

// ---- logic/hvac_seq_pkg.sv ----
package hvac_seq_pkg;
  typedef enum logic [1:0] {
    comp_single_stage,
    comp_one_staged,
    comp_two_fixed
  } comp_kind_t;

  typedef struct packed {
    logic       heat_pump_type;
    comp_kind_t comp_kind;
    logic       fixed_speed_outdoor_motor;
    logic [6:0] cool_one_speed;
    logic [6:0] cool_two_speed;
    logic [6:0] aux_heat_speed;
    logic [6:0] dehum_speed;
    logic [6:0] fan_max_speed;
    logic [7:0] purge_seconds;
  } config_t;

  typedef struct packed {
    logic       compressor_a_output;
    logic       compressor_b_output;
    logic       valve_reverse_output;
    logic       outdoor_fan_relay_output;
    logic       heater_output;
    logic       blower_on;
    logic [6:0] blower_speed;
    logic [6:0] outdoor_fan_speed;
  } drive_t;
endpackage

// ---- logic/hvac_request_sequencer.sv ----
// Operation
// - a call counts only after 5 s of continuous assertion
// - compressor outputs start 5 s apart to limit inrush
// - discrete input and serial-link request are the same call
// - lone fan call runs blower at stage-two speed
// - cooling, aux heat, dehumidify each run blower at own speed
// - speed priority: cool two, cool one, aux, dehumidify, fan last
// - every operating call also runs the blower
// - cooling speeds come from settings four and five
// - air conditioner never runs compressor with heater
// - heat pump may run compressor and heater together
// - setting one picks air conditioner or heat pump sequence
// - one staged compressor: cool one partial, both calls full
// - two fixed compressors: lone call drives matching output
// - heat-pump cooling with valve call energises reversing valve while the first compressor is wanted
// - modulating fan stops below 80F, scales 80F to 115F
// - above 115F outdoor fan runs at setting-eight maximum
// - fixed-speed motor relay on at 400 PSIG, off at 290
// - stage-two call adds second compressor and stage-two speed
// - operating call end drops compressors and fan, blower purges
// - single-stage compressor gives full capacity on cool one
// - second compressor output never stands without the first, except with two fixed compressors
// - staging only while no active fault
// - aux heat speed defaults to 100 percent
// - dehumidify speed defaults to 80 percent
`include "hvac_seq_defs.svh"

module hvac_request_sequencer
  import hvac_seq_pkg::*;
#(
  parameter longint unsigned CALL_DELAY = `CALL_DELAY_CYC,
  parameter longint unsigned STAGGER    = `STAGGER_CYC,
  parameter longint unsigned SEC_CYC    = `CYC_PER_SEC
) (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       fan_only_pin,
  input  wire logic       cool_stage_one_pin,
  input  wire logic       cool_stage_two_pin,
  input  wire logic       aux_heat_pin,
  input  wire logic       dehumidify_pin,
  input  wire logic       valve_pin,
  input  wire logic [5:0] link_requests,
  input  wire logic       link_valid,
  input  wire logic       heat_pump_type,
  input  wire logic [1:0] comp_kind_sel,
  input  wire logic       fixed_speed_outdoor_motor,
  input  wire logic [6:0] cool_one_speed,
  input  wire logic [6:0] cool_two_speed,
  input  wire logic [6:0] aux_heat_speed,
  input  wire logic [6:0] dehum_speed,
  input  wire logic [6:0] fan_max_speed,
  input  wire logic [7:0] purge_seconds,
  input  wire logic       fault_active,
  input  wire logic       fan_pressure_switch,
  input  wire logic [7:0] liquid_line_sensor_input,
  output logic            compressor_a_output,
  output logic            compressor_b_output,
  output logic            valve_reverse_output,
  output logic            outdoor_fan_relay_output,
  output logic            heater_output,
  output logic            blower_on,
  output logic [6:0]      blower_speed,
  output logic [6:0]      outdoor_fan_speed,
  output logic [5:0]      valid_calls
);

  // ------------------------------------------------------------------
  // timing limits
  // ------------------------------------------------------------------
  // 40 bits hold five seconds of cycles at the full clock rate
  localparam int unsigned CW = 40;
  localparam logic [CW-1:0] CALL_LIM = CW'(CALL_DELAY);
  localparam logic [CW-1:0] STAG_LIM = CW'(STAGGER);
  localparam logic [CW-1:0] SEC_LIM  = CW'(SEC_CYC);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    // call synchronisers and link latch
    logic [`CALL_N-1:0]          sync1;
    logic [`CALL_N-1:0]          sync2;
    logic [`CALL_N-1:0]          link_hold;
    // per-call time-on filter
    logic [`CALL_N-1:0][CW-1:0]  dly;
    logic [`CALL_N-1:0]          valid;
    // compressor stagger
    logic [CW-1:0]               stag_cnt;
    logic                        stag_done;
    // purge timing
    logic [CW-1:0]               sec_cnt;
    logic [7:0]                  purge_left;
    logic [6:0]                  purge_speed;
    // switch, sensor and fault synchronisers
    logic [1:0]                  psw_sync;
    logic [7:0]                  ll_s1;
    logic [7:0]                  ll_s2;
    logic [1:0]                  flt_sync;
    // sampled settings and registered drive
    config_t                     cfg;
    drive_t                      drv;
  } state_t;

  state_t q, d;

  // link bits stay latched until the next strobe rewrites them
  // raw call vector: pins synchronised, link requests held
  logic [`CALL_N-1:0] pin_vec;
  logic [`CALL_N-1:0] raw_call;
  assign pin_vec = {valve_pin, dehumidify_pin, aux_heat_pin,
                    cool_stage_two_pin, cool_stage_one_pin, fan_only_pin};
  assign raw_call = q.sync2 | q.link_hold;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    logic       want_a;
    logic       want_b;
    logic       any_cool;
    logic       any_op;
    logic [6:0] spd;
    logic [7:0] ll;
    logic [13:0] prod;
    // defaults keep every path assigned
    d = q;
    want_a = 1'b0;
    want_b = 1'b0;
    any_cool = 1'b0;
    any_op = 1'b0;
    spd = 7'h00;
    ll = q.ll_s2;
    prod = 14'h0000;

    // two flops on every pin, switch, sensor and fault input
    d.sync1 = pin_vec;
    d.sync2 = q.sync1;
    d.psw_sync = {q.psw_sync[0], fan_pressure_switch};
    d.flt_sync = {q.flt_sync[0], fault_active};
    d.ll_s1 = liquid_line_sensor_input;
    d.ll_s2 = q.ll_s1;
    // link calls come from same-clock logic and skip the flops
    if (link_valid) begin
      d.link_hold = link_requests;
    end

    // configuration sampled each cycle
    // reset defaults stand only until the first edge after release
    d.cfg.heat_pump_type = heat_pump_type;
    d.cfg.comp_kind = comp_kind_t'(comp_kind_sel);
    d.cfg.fixed_speed_outdoor_motor = fixed_speed_outdoor_motor;
    d.cfg.cool_one_speed = cool_one_speed;
    d.cfg.cool_two_speed = cool_two_speed;
    d.cfg.aux_heat_speed = aux_heat_speed;
    d.cfg.dehum_speed = dehum_speed;
    d.cfg.fan_max_speed = fan_max_speed;
    d.cfg.purge_seconds = purge_seconds;

    // time-on filter per call; a drop restarts the count
    // the count saturates, so a held call keeps its valid bit high
    // pin calls arrive two cycles late through their flops
    for (int i = 0; i < `CALL_N; i++) begin
      if (!raw_call[i]) begin
        d.dly[i] = '0;
        d.valid[i] = 1'b0;
      end else if (q.dly[i] >= CALL_LIM - CW'(1)) begin
        d.valid[i] = 1'b1;
      end else begin
        d.dly[i] = q.dly[i] + CW'(1);
      end
    end

    any_cool = q.valid[`CALL_COOL1] | q.valid[`CALL_COOL2];
    any_op = any_cool | q.valid[`CALL_AUX] | q.valid[`CALL_DEHUM];

    // ------------------------------------------------------------
    // compressors
    // ------------------------------------------------------------
    // compressor demand by compressor arrangement
    case (q.cfg.comp_kind)
      comp_single_stage: begin
        want_a = any_cool;
      end
      comp_one_staged: begin
        want_a = any_cool;
        want_b = q.valid[`CALL_COOL1] & q.valid[`CALL_COOL2];
      end
      comp_two_fixed: begin
        want_a = q.valid[`CALL_COOL1];
        want_b = q.valid[`CALL_COOL2];
      end
      default: begin
        // no compressor fitted: nothing starts
        want_a = 1'b0;
      end
    endcase
    if (q.cfg.comp_kind != comp_two_fixed) begin
      want_b = want_b & want_a;
    end
    // air conditioner: cooling beats heat, never both
    // heat pump lets heat and compressor share the call
    if (!q.cfg.heat_pump_type && any_cool) begin
      d.drv.heater_output = 1'b0;
    end else begin
      d.drv.heater_output = q.valid[`CALL_AUX];
    end
    // a fault drops compressors and heater, so valve and outdoor fan follow; blower and filters keep running
    if (q.flt_sync[1]) begin
      want_a = 1'b0;
      want_b = 1'b0;
      d.drv.heater_output = 1'b0;
    end

    // stagger: the second start waits one delay after the first
    if (!(want_a && want_b)) begin
      d.stag_cnt = '0;
      d.stag_done = 1'b0;
    end else if (q.drv.compressor_a_output && !q.stag_done) begin
      if (q.stag_cnt >= STAG_LIM - CW'(1)) begin
        d.stag_done = 1'b1;
      end else begin
        d.stag_cnt = q.stag_cnt + CW'(1);
      end
    end
    d.drv.compressor_a_output = want_a;
    // b reads the next done value: a registered done would stretch the
    // gap to one cycle past the stagger limit
    if (q.cfg.comp_kind == comp_two_fixed && !want_a) begin
      d.drv.compressor_b_output = want_b;
    end else begin
      d.drv.compressor_b_output = want_b & d.stag_done;
    end
    d.drv.valve_reverse_output = q.cfg.heat_pump_type & want_a
                                 & q.valid[`CALL_VALVE];

    // ------------------------------------------------------------
    // indoor blower
    // ------------------------------------------------------------
    // blower speed by priority
    // fan-only falls through to the last branch, below every call
    if (q.valid[`CALL_COOL2]) begin
      spd = q.cfg.cool_two_speed;
    end else if (q.valid[`CALL_COOL1]) begin
      spd = q.cfg.cool_one_speed;
    end else if (q.valid[`CALL_AUX]) begin
      spd = q.cfg.aux_heat_speed;
    end else if (q.valid[`CALL_DEHUM]) begin
      spd = q.cfg.dehum_speed;
    end else begin
      spd = q.cfg.cool_two_speed;
    end

    // purge: blower outlives the call by the set seconds
    // whole seconds of one shared counter, so the purge may run up to
    // one second short; one counter was worth that
    if (q.sec_cnt >= SEC_LIM - CW'(1)) begin
      d.sec_cnt = '0;
    end else begin
      d.sec_cnt = q.sec_cnt + CW'(1);
    end
    if (any_op) begin
      d.purge_left = q.cfg.purge_seconds;
      d.purge_speed = spd;
    end else if (q.purge_left != 8'h00 && q.sec_cnt == '0) begin
      d.purge_left = q.purge_left - 8'h01;
    end

    // blower: any call except valve, then the purge, else off
    // fan-only keeps its speed but never starts a purge
    if (any_op || q.valid[`CALL_FAN]) begin
      d.drv.blower_on = 1'b1;
      d.drv.blower_speed = spd;
    end else if (q.purge_left != 8'h00) begin
      d.drv.blower_on = 1'b1;
      d.drv.blower_speed = q.purge_speed;
    end else begin
      d.drv.blower_on = 1'b0;
      d.drv.blower_speed = 7'h00;
    end

    // ------------------------------------------------------------
    // outdoor fan
    // ------------------------------------------------------------
    // outdoor fan: relay for fixed motor, speed for modulating
    // runs only with the first compressor; a lone b has no fan
    d.drv.outdoor_fan_relay_output = 1'b0;
    d.drv.outdoor_fan_speed = 7'h00;
    if (want_a) begin
      if (q.cfg.fixed_speed_outdoor_motor) begin
        // switch hysteresis (400 close, 290 open) lives in the switch
        d.drv.outdoor_fan_relay_output = q.psw_sync[1];
      end else if (ll > `LL_MAX_F) begin
        d.drv.outdoor_fan_speed = q.cfg.fan_max_speed;
      end else if (ll >= `LL_STOP_F) begin
        // linear ramp; crosses mid-range near 97.5F, above the 90F target
        prod = 14'(ll - `LL_STOP_F) * 14'(q.cfg.fan_max_speed);
        d.drv.outdoor_fan_speed =
          7'(prod / 14'(`LL_MAX_F - `LL_STOP_F));
      end
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  // async reset loads defaults, constants only
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.cfg.aux_heat_speed <= `AUX_SPEED_RST;
      q.cfg.dehum_speed <= `DEHUM_SPEED_RST;
      q.cfg.cool_one_speed <= `STAGE_SPEED_RST;
      q.cfg.cool_two_speed <= `STAGE_SPEED_RST;
      q.cfg.fan_max_speed <= `FAN_MAX_RST;
      q.cfg.purge_seconds <= `PURGE_DEFAULT_S;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // every output comes straight from the state register
  assign compressor_a_output = q.drv.compressor_a_output;
  assign compressor_b_output = q.drv.compressor_b_output;
  assign valve_reverse_output = q.drv.valve_reverse_output;
  assign outdoor_fan_relay_output = q.drv.outdoor_fan_relay_output;
  assign heater_output = q.drv.heater_output;
  assign blower_on = q.drv.blower_on;
  assign blower_speed = q.drv.blower_speed;
  assign outdoor_fan_speed = q.drv.outdoor_fan_speed;
  assign valid_calls = q.valid;

endmodule // hvac_request_sequencer

// ---- verification/hvac_seq_sva.sv ----
module hvac_seq_sva
  import hvac_seq_pkg::*;
#(
  parameter int CALL_DELAY = 10,
  parameter int STAGGER    = 10
) (
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic       cool_stage_one_pin,
  input wire logic       heat_pump_type,
  input wire logic [1:0] comp_kind_sel,
  input wire logic       fault_active,
  input wire logic       fixed_speed_outdoor_motor,
  input wire logic [7:0] liquid_line_sensor_input,
  input wire logic [6:0] fan_max_speed,
  input wire logic       compressor_a_output,
  input wire logic       compressor_b_output,
  input wire logic       valve_reverse_output,
  input wire logic       outdoor_fan_relay_output,
  input wire logic       heater_output,
  input wire logic       blower_on,
  input wire logic [6:0] outdoor_fan_speed,
  input wire logic [5:0] valid_calls,
  input wire logic [5:0] link_requests
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // sequencing checks, one clock domain
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_filter;
    // the call may stand on the pin or on the link
    $rose(valid_calls[1])
      |-> $past(cool_stage_one_pin || link_requests[1], CALL_DELAY);
  endproperty
  a_filter: assert property (p_filter) else $error("call too early");
  // one staged: b may only rise if a was on STAGGER - 1 cycles before
  property p_stagger;
    $rose(compressor_b_output) && comp_kind_sel == 2'h1
      |-> $past(compressor_a_output, STAGGER - 1);
  endproperty
  a_stagger: assert property (p_stagger) else $error("no stagger");
  property p_b_needs_a;
    compressor_b_output && comp_kind_sel != 2'h2 |-> compressor_a_output;
  endproperty
  a_b_needs_a: assert property (p_b_needs_a) else $error("b alone");
  property p_ac_heat;
    !heat_pump_type && $past(!heat_pump_type)
      |-> !(heater_output && (compressor_a_output || compressor_b_output));
  endproperty
  a_ac_heat: assert property (p_ac_heat) else $error("heat with comp");
  property p_fault;
    fault_active [*4] |-> !compressor_a_output && !compressor_b_output
      && !heater_output && !valve_reverse_output;
  endproperty
  a_fault: assert property (p_fault) else $error("runs in fault");
  property p_drop;
    valid_calls == 6'h00 |=> !compressor_a_output && !compressor_b_output
      && !outdoor_fan_relay_output && outdoor_fan_speed == 7'h00;
  endproperty
  a_drop: assert property (p_drop) else $error("no drop");
  property p_fan_max;
    (!fixed_speed_outdoor_motor && liquid_line_sensor_input > 8'h73) [*4]
      ##0 compressor_a_output |-> outdoor_fan_speed == fan_max_speed;
  endproperty
  a_fan_max: assert property (p_fan_max) else $error("fan not max");
  property p_interlock;
    compressor_a_output |-> blower_on;
  endproperty
  a_interlock: assert property (p_interlock) else $error("no blower");
endmodule // hvac_seq_sva

bind hvac_request_sequencer hvac_seq_sva #(
  .CALL_DELAY(int'(CALL_DELAY)),
  .STAGGER   (int'(STAGGER))
) sva_u (.core_clk, .reset_n, .cool_stage_one_pin, .heat_pump_type,
  .comp_kind_sel, .fault_active, .fixed_speed_outdoor_motor,
  .liquid_line_sensor_input, .fan_max_speed, .compressor_a_output,
  .compressor_b_output, .valve_reverse_output, .outdoor_fan_relay_output,
  .heater_output, .blower_on, .outdoor_fan_speed, .valid_calls,
  .link_requests);

// ---- verification/thermostat_model.sv ----
module thermostat_model (
  input  wire logic       core_clk,
  input  wire logic [5:0] demand,
  output logic      [5:0] call_pins
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // wall thermostat: calls are held levels, moved just after edges
  // ------------------------------------------------------------
  initial call_pins = 6'h00;
  always @(posedge core_clk) begin
    call_pins <= #1 demand;
  end
endmodule // thermostat_model

// ---- verification/hvac_request_sequencer_tb_top.sv ----
module hvac_request_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // stimulus, expectation queue and call monitor
  // ------------------------------------------------------------
  localparam int STG = 10;
  logic       core_clk = 1'b0;
  logic       reset_n, link_valid, heat_pump_type, fault_active;
  logic       fixed_speed_outdoor_motor, fan_pressure_switch;
  logic       compressor_a_output, compressor_b_output, heater_output;
  logic       valve_reverse_output, outdoor_fan_relay_output, blower_on;
  logic [1:0] comp_kind_sel;
  logic [5:0] demand, pins, link_requests, valid_calls, seen_q, e;
  logic [6:0] s1, s2, sa, sd, sm, blower_speed, outdoor_fan_speed;
  logic [7:0] purge_seconds, liquid_line_sensor_input;
  logic [5:0] exp_q[$];
  int         fail_count = 0;
  int         cmp_count = 0;
  integer     seed = 32'h71B1CFF8;
  always #2 core_clk = ~core_clk;
  thermostat_model tstat_u (.core_clk, .demand, .call_pins(pins));
  hvac_request_sequencer #(.CALL_DELAY(10), .STAGGER(STG), .SEC_CYC(5))
  dut_u (.core_clk, .reset_n, .fan_only_pin(pins[0]),
    .cool_stage_one_pin(pins[1]), .cool_stage_two_pin(pins[2]),
    .aux_heat_pin(pins[3]), .dehumidify_pin(pins[4]), .valve_pin(pins[5]),
    .link_requests, .link_valid, .heat_pump_type, .comp_kind_sel,
    .fixed_speed_outdoor_motor, .cool_one_speed(s1), .cool_two_speed(s2),
    .aux_heat_speed(sa), .dehum_speed(sd), .fan_max_speed(sm),
    .purge_seconds, .fault_active, .fan_pressure_switch,
    .liquid_line_sensor_input, .compressor_a_output, .compressor_b_output,
    .valve_reverse_output, .outdoor_fan_relay_output, .heater_output,
    .blower_on, .blower_speed, .outdoor_fan_speed, .valid_calls);
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [6:0] x, input logic [6:0] g);
    cmp_count++;
    if (g !== x) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // bounded wait: a call that never settles ends the run
  task automatic wait_calls(input logic [5:0] v);
    for (int i = 0; i < 60 && valid_calls !== v; i++) tick(1);
    if (valid_calls !== v) begin
      cmp("valid_calls", 7'(v), 7'(valid_calls));
      report_and_stop();
    end
  endtask
  task automatic send(input logic lnk, input logic [5:0] v);
    exp_q.push_back(v);
    if (lnk) begin
      link_requests = v;
      link_valid = 1'b1;
      tick(1);
      link_valid = 1'b0;
    end else demand = v;
    wait_calls(v);
  endtask
  // mid-band expected as (T - 80) * max / 35, truncated
  task automatic fan_checks();
    int fe;
    repeat (3) begin
      liquid_line_sensor_input = 8'($random(seed));
      tick(5);
      fe = (int'(liquid_line_sensor_input) - 80) * int'(sm) / 35;
      if (liquid_line_sensor_input > 8'h73) begin
        cmp("fan", sm, outdoor_fan_speed);
      end else if (liquid_line_sensor_input < 8'h50) begin
        cmp("fan", 7'h00, outdoor_fan_speed);
      end else begin
        cmp("fan", 7'(fe), outdoor_fan_speed);
      end
    end
    fixed_speed_outdoor_motor = 1'b1;
    fan_pressure_switch = 1'b1;
    tick(5);
    cmp("relay", 7'h01, 7'(outdoor_fan_relay_output));
    fan_pressure_switch = 1'b0;
    tick(5);
    cmp("relay", 7'h00, 7'(outdoor_fan_relay_output));
    fixed_speed_outdoor_motor = 1'b0;
  endtask
  task automatic run_case(input logic [5:0] d, input logic [1:0] k,
    input logic hp, input logic lnk, input logic [2:0] abv,
    input logic [6:0] sp);
    logic ht;
    ht = d[3] & (hp | (d[2:1] == 2'b00));
    comp_kind_sel = k;
    heat_pump_type = hp;
    send(lnk, d);
    tick(STG);
    if (abv[2] & abv[1]) cmp("b_early", 7'h00, 7'(compressor_b_output));
    tick(3);
    cmp("comp_a", 7'(abv[2]), 7'(compressor_a_output));
    cmp("comp_b", 7'(abv[1]), 7'(compressor_b_output));
    cmp("valve", 7'(abv[0]), 7'(valve_reverse_output));
    cmp("blower_on", 7'h01, 7'(blower_on));
    cmp("blower_speed", sp, blower_speed);
    cmp("heater", 7'(ht), 7'(heater_output));
    if (abv[2]) fan_checks();
    send(lnk, 6'h00);
    tick(2);
    cmp("comp_a_off", 7'h00, 7'(compressor_a_output));
    if (d[4:1] != 4'h0) begin
      cmp("purge", 7'h01, 7'(blower_on));
      cmp("purge_speed", sp, blower_speed);
    end else cmp("no_purge", 7'h00, 7'(blower_on));
    tick(15);
    cmp("purge_end", 7'h00, 7'(blower_on));
    $display("case %h done", d);
  endtask
  // each change of the filtered calls takes the oldest note
  always @(negedge core_clk) begin
    if (reset_n === 1'b1 && valid_calls !== seen_q) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 6'hXX;
      cmp("valid_calls", 7'(e), 7'(valid_calls));
      seen_q = valid_calls;
    end
  end
  initial begin
    {reset_n, link_valid, heat_pump_type, fault_active} = 4'h0;
    {fixed_speed_outdoor_motor, fan_pressure_switch} = 2'h0;
    {comp_kind_sel, demand, link_requests, seen_q} = 20'h00000;
    {s1, s2} = {7'({$random(seed)} % 100), 7'({$random(seed)} % 100)};
    {sa, sd} = {7'({$random(seed)} % 100), 7'({$random(seed)} % 100)};
    sm = 7'h64;
    purge_seconds = 8'h02;
    liquid_line_sensor_input = 8'h5A;
    tick(20);
    reset_n = 1'b1;
    tick(2);
    demand = 6'h02;
    tick(5);
    demand = 6'h00;
    tick(25);
    $display("short pulse done");
    run_case(6'h01, 2'h1, 1'b0, 1'b0, 3'b000, s2);
    run_case(6'h02, 2'h1, 1'b0, 1'b0, 3'b100, s1);
    run_case(6'h06, 2'h1, 1'b0, 1'b0, 3'b110, s2);
    run_case(6'h04, 2'h2, 1'b0, 1'b1, 3'b010, s2);
    run_case(6'h22, 2'h1, 1'b1, 1'b0, 3'b101, s1);
    run_case(6'h18, 2'h1, 1'b0, 1'b0, 3'b000, sa);
    run_case(6'h10, 2'h1, 1'b0, 1'b0, 3'b000, sd);
    run_case(6'h0A, 2'h1, 1'b1, 1'b0, 3'b100, s1);
    run_case(6'h06, 2'h0, 1'b0, 1'b1, 3'b100, s2);
    run_case(6'h02, 2'h3, 1'b0, 1'b0, 3'b000, s1);
    run_case(6'h0F, 2'h1, 1'b0, 1'b1, 3'b110, s2);
    send(1'b0, 6'h02);
    tick(STG);
    cmp("pre_fault_comp_a", 7'h01, 7'(compressor_a_output));
    fault_active = 1'b1;
    tick(5);
    cmp("fault_comp_a", 7'h00, 7'(compressor_a_output));
    fault_active = 1'b0;
    send(1'b0, 6'h00);
    $display("fault done");
    report_and_stop();
  end
endmodule // hvac_request_sequencer_tb_top
